// ### rtl/timer_pkg.sv
// constants, field positions and carrier types of the timer block
package timer_pkg;

	// control field positions
	localparam int RUN_BIT = 15;
	localparam int IDLE_BIT = 13;
	localparam int GATE_BIT = 6;
	localparam int PRE_HI = 5;
	localparam int PRE_LO = 4;
	localparam int PAIR_BIT = 3;
	localparam int SYNC_BIT = 2;
	localparam int SRC_BIT = 1;

	// register offsets
	localparam logic [3:0] OFS_FIRST_CTRL = 4'h0;
	localparam logic [3:0] OFS_FIRST_COUNT = 4'h1;
	localparam logic [3:0] OFS_FIRST_PERIOD = 4'h2;
	localparam logic [3:0] OFS_LOWER_CTRL = 4'h3;
	localparam logic [3:0] OFS_LOWER_COUNT = 4'h4;
	localparam logic [3:0] OFS_LOWER_PERIOD = 4'h5;
	localparam logic [3:0] OFS_UPPER_CTRL = 4'h6;
	localparam logic [3:0] OFS_UPPER_COUNT = 4'h7;
	localparam logic [3:0] OFS_UPPER_PERIOD = 4'h8;
	localparam logic [3:0] OFS_IRQ_FLAGS = 4'h9;
	localparam logic [3:0] OFS_IRQ_CTRL = 4'hA;

	// implemented bits of each register
	localparam logic [15:0] FIRST_CTRL_MASK = 16'hA076;
	localparam logic [15:0] LOWER_CTRL_MASK = 16'hA07A;
	localparam logic [15:0] UPPER_CTRL_MASK = 16'hA072;
	localparam logic [15:0] IRQ_CTRL_MASK = 16'h7777;
	localparam logic [15:0] IRQ_FLAGS_MASK = 16'h0007;

	// values after reset
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
	localparam logic [15:0] IRQ_CTRL_RESET = 16'h0000;

	// prescaler terminal counts
	localparam logic [7:0] PRE_LIM_1 = 8'h00;
	localparam logic [7:0] PRE_LIM_8 = 8'h07;
	localparam logic [7:0] PRE_LIM_64 = 8'h3F;
	localparam logic [7:0] PRE_LIM_256 = 8'hFF;

	typedef struct packed {
		logic upper;
		logic lower;
		logic first;
	} count_pins_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [15:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic [2:0] req;
		logic [2:0] prio_upper;
		logic [2:0] prio_lower;
		logic [2:0] prio_first;
	} irq_out_type;

	typedef struct packed {
		logic [15:0] ctrl1;
		logic [15:0] ctrl2;
		logic [15:0] ctrl3;
		logic [15:0] cnt1;
		logic [15:0] cnt2;
		logic [15:0] cnt3;
		logic [15:0] per1;
		logic [15:0] per2;
		logic [15:0] per3;
		logic [15:0] irq_ctrl;
		logic [7:0] pre1;
		logic [7:0] pre2;
		logic [7:0] pre3;
		logic [2:0] raw_prev;
		logic [2:0] sy1;
		logic [2:0] sy2;
		logic [2:0] sy_prev;
		logic [1:0] post1;
		logic [1:0] post2;
		logic [2:0] flags;
		logic [2:0] irq;
		logic [15:0] rdata;
	} state_type;

endpackage

// ### rtl/paired_timers.sv
// three 16-bit timers, the second and third joinable into one 32-bit count
`timescale 1ns/1ns
module paired_timers (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// register port
	input wire timer_pkg::bus_req_type bus_req,
	output logic [15:0] bus_rdata,
	// device state and pins
	input wire logic idle_mode,
	input wire timer_pkg::count_pins_type count_pins,
	// interrupt requests
	output timer_pkg::irq_out_type irq_out
);

	timer_pkg::state_type st_q;
	timer_pkg::state_type st_d;
	logic [2:0] raw_e;
	logic [2:0] syn_e;
	logic [2:0] gfall;
	logic run1;
	logic run2;
	logic run3;
	logic paired;
	logic gated1;
	logic gated2;
	logic gated3;
	logic ptick1;
	logic ptick2;
	logic ptick3;
	logic tick1;
	logic tick2;
	logic tick3;

	// terminal count of a prescale code
	function automatic logic [7:0] presc_lim(input logic [1:0] code);
		logic [7:0] r;
		r = timer_pkg::PRE_LIM_1;
		unique case (code)
			2'b00: r = timer_pkg::PRE_LIM_1;
			2'b01: r = timer_pkg::PRE_LIM_8;
			2'b10: r = timer_pkg::PRE_LIM_64;
			2'b11: r = timer_pkg::PRE_LIM_256;
		endcase
		return r;
	endfunction

	// prescaler step, returns {tick, next}
	function automatic logic [8:0] presc_step(input logic [7:0] pre,
			input logic [1:0] code, input logic ev);
		logic [8:0] r;
		r = {1'b0, pre};
		if (ev) begin
			if (pre >= presc_lim(code)) begin
				r = {1'b1, 8'h00};
			end else begin
				r = {1'b0, pre + 8'h01};
			end
		end
		return r;
	endfunction

	// count step against period, returns {match, next}
	function automatic logic [16:0] cnt_step(input logic [15:0] cnt,
			input logic [15:0] per);
		logic [16:0] r;
		if (cnt == per) begin
			r = {1'b1, 16'h0000};
		end else begin
			r = {1'b0, cnt + 16'h0001};
		end
		return r;
	endfunction

	// event into a prescaler: pin edge, gate level or every clock
	function automatic logic src_ev(input logic ext, input logic gated,
			input logic ext_ev, input logic gate_lvl);
		logic r;
		if (ext) begin
			r = ext_ev;
		end else if (gated) begin
			r = gate_lvl;
		end else begin
			r = 1'b1;
		end
		return r;
	endfunction

	always_comb begin
		logic [8:0] ps1;
		logic [8:0] ps2;
		logic [8:0] ps3;
		logic [16:0] cs1;
		logic [16:0] cs2;
		logic [16:0] cs3;
		logic [31:0] c32;
		logic [31:0] p32;
		logic [2:0] set;
		logic [2:0] clr;
		logic clr_pre1;
		logic clr_pre2;
		logic clr_pre3;
		ps1 = '0;
		ps2 = '0;
		ps3 = '0;
		cs1 = '0;
		cs2 = '0;
		cs3 = '0;
		set = 3'b000;
		clr = 3'b000;
		c32 = {st_q.cnt3, st_q.cnt2};
		p32 = {st_q.per3, st_q.per2};
		clr_pre1 = 1'b0;
		clr_pre2 = 1'b0;
		clr_pre3 = 1'b0;
		st_d = st_q;

		// pin edges, synchronisers and gate edges
		st_d.raw_prev = count_pins;
		st_d.sy1 = count_pins;
		st_d.sy2 = st_q.sy1;
		st_d.sy_prev = st_q.sy2;
		raw_e = count_pins & ~st_q.raw_prev;
		syn_e = st_q.sy2 & ~st_q.sy_prev;
		gfall = ~st_q.sy2 & st_q.sy_prev;

		paired = st_q.ctrl2[timer_pkg::PAIR_BIT];
		run1 = st_q.ctrl1[timer_pkg::RUN_BIT]
			& ~(idle_mode & st_q.ctrl1[timer_pkg::IDLE_BIT]);
		run2 = st_q.ctrl2[timer_pkg::RUN_BIT]
			& ~(idle_mode & (st_q.ctrl2[timer_pkg::IDLE_BIT]
			| (paired & st_q.ctrl3[timer_pkg::IDLE_BIT])));
		run3 = st_q.ctrl3[timer_pkg::RUN_BIT] & ~paired
			& ~(idle_mode & st_q.ctrl3[timer_pkg::IDLE_BIT]);
		gated1 = st_q.ctrl1[timer_pkg::GATE_BIT]
			& ~st_q.ctrl1[timer_pkg::SRC_BIT];
		gated2 = st_q.ctrl2[timer_pkg::GATE_BIT]
			& ~st_q.ctrl2[timer_pkg::SRC_BIT];
		gated3 = st_q.ctrl3[timer_pkg::GATE_BIT]
			& ~st_q.ctrl3[timer_pkg::SRC_BIT];

		// prescalers
		ps1 = presc_step(st_q.pre1,
			st_q.ctrl1[timer_pkg::PRE_HI:timer_pkg::PRE_LO],
			run1 & src_ev(st_q.ctrl1[timer_pkg::SRC_BIT], gated1,
			raw_e[0], st_q.sy2[0]));
		ps2 = presc_step(st_q.pre2,
			st_q.ctrl2[timer_pkg::PRE_HI:timer_pkg::PRE_LO],
			run2 & src_ev(st_q.ctrl2[timer_pkg::SRC_BIT], gated2,
			raw_e[1], st_q.sy2[1]));
		ps3 = presc_step(st_q.pre3,
			st_q.ctrl3[timer_pkg::PRE_HI:timer_pkg::PRE_LO],
			run3 & src_ev(st_q.ctrl3[timer_pkg::SRC_BIT], gated3,
			syn_e[2], st_q.sy2[2]));
		ptick1 = ps1[8];
		ptick2 = ps2[8];
		ptick3 = ps3[8];
		st_d.pre1 = ps1[7:0];
		st_d.pre2 = ps2[7:0];
		st_d.pre3 = ps3[7:0];

		// synchronise prescaled pin ticks
		st_d.post1 = {st_q.post1[0], ptick1};
		st_d.post2 = {st_q.post2[0], ptick2};
		if (st_q.ctrl1[timer_pkg::SRC_BIT]
				& st_q.ctrl1[timer_pkg::SYNC_BIT]) begin
			tick1 = st_q.post1[1] & run1;
		end else begin
			tick1 = ptick1;
		end
		if (st_q.ctrl2[timer_pkg::SRC_BIT]) begin
			tick2 = st_q.post2[1] & run2;
		end else begin
			tick2 = ptick2;
		end
		tick3 = ptick3;

		// first timer
		cs1 = cnt_step(st_q.cnt1, st_q.per1);
		if (tick1) begin
			st_d.cnt1 = cs1[15:0];
			set[0] = cs1[16] & ~gated1;
		end
		if (run1 & gated1 & gfall[0]) begin
			set[0] = 1'b1;
		end

		// lower and upper timers, alone or as a pair
		if (paired) begin
			if (tick2) begin
				if (c32 == p32) begin
					c32 = 32'h0000_0000;
					set[2] = ~gated2;
				end else begin
					c32 = c32 + 32'h0000_0001;
				end
				st_d.cnt3 = c32[31:16];
				st_d.cnt2 = c32[15:0];
			end
			if (run2 & gated2 & gfall[1]) begin
				set[2] = 1'b1;
			end
		end else begin
			cs2 = cnt_step(st_q.cnt2, st_q.per2);
			cs3 = cnt_step(st_q.cnt3, st_q.per3);
			if (tick2) begin
				st_d.cnt2 = cs2[15:0];
				set[1] = cs2[16] & ~gated2;
			end
			if (tick3) begin
				st_d.cnt3 = cs3[15:0];
				set[2] = cs3[16] & ~gated3;
			end
			set[1] = set[1] | (run2 & gated2 & gfall[1]);
			set[2] = set[2] | (run3 & gated3 & gfall[2]);
		end

		// register writes; a write beats a same-cycle count step
		if (bus_req.wr) begin
			unique case (bus_req.addr)
				timer_pkg::OFS_FIRST_CTRL: begin
					st_d.ctrl1 = bus_req.wdata & timer_pkg::FIRST_CTRL_MASK;
					clr_pre1 = 1'b1;
				end
				timer_pkg::OFS_FIRST_COUNT: begin
					st_d.cnt1 = bus_req.wdata;
					clr_pre1 = 1'b1;
				end
				timer_pkg::OFS_FIRST_PERIOD: st_d.per1 = bus_req.wdata;
				timer_pkg::OFS_LOWER_CTRL: begin
					st_d.ctrl2 = bus_req.wdata & timer_pkg::LOWER_CTRL_MASK;
					clr_pre2 = 1'b1;
				end
				timer_pkg::OFS_LOWER_COUNT: begin
					st_d.cnt2 = bus_req.wdata;
					clr_pre2 = 1'b1;
				end
				timer_pkg::OFS_LOWER_PERIOD: st_d.per2 = bus_req.wdata;
				timer_pkg::OFS_UPPER_CTRL: begin
					st_d.ctrl3 = bus_req.wdata & timer_pkg::UPPER_CTRL_MASK;
					clr_pre3 = 1'b1;
				end
				timer_pkg::OFS_UPPER_COUNT: begin
					st_d.cnt3 = bus_req.wdata;
					clr_pre3 = 1'b1;
				end
				timer_pkg::OFS_UPPER_PERIOD: st_d.per3 = bus_req.wdata;
				timer_pkg::OFS_IRQ_FLAGS: clr = bus_req.wdata[2:0];
				timer_pkg::OFS_IRQ_CTRL:
					st_d.irq_ctrl = bus_req.wdata & timer_pkg::IRQ_CTRL_MASK;
				default: ;
			endcase
		end
		if (clr_pre1) begin
			st_d.pre1 = 8'h00;
		end
		if (clr_pre2) begin
			st_d.pre2 = 8'h00;
		end
		if (clr_pre3) begin
			st_d.pre3 = 8'h00;
		end

		// set wins over a write-one clear
		st_d.flags = (st_q.flags & ~clr) | set;
		st_d.irq = st_q.flags & st_q.irq_ctrl[2:0]
			& {1'b1, ~paired, 1'b1};

		// read data, one cycle later
		st_d.rdata = 16'h0000;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				timer_pkg::OFS_FIRST_CTRL: st_d.rdata = st_q.ctrl1;
				timer_pkg::OFS_FIRST_COUNT: st_d.rdata = st_q.cnt1;
				timer_pkg::OFS_FIRST_PERIOD: st_d.rdata = st_q.per1;
				timer_pkg::OFS_LOWER_CTRL: st_d.rdata = st_q.ctrl2;
				timer_pkg::OFS_LOWER_COUNT: st_d.rdata = st_q.cnt2;
				timer_pkg::OFS_LOWER_PERIOD: st_d.rdata = st_q.per2;
				timer_pkg::OFS_UPPER_CTRL: st_d.rdata = st_q.ctrl3;
				timer_pkg::OFS_UPPER_COUNT: st_d.rdata = st_q.cnt3;
				timer_pkg::OFS_UPPER_PERIOD: st_d.rdata = st_q.per3;
				timer_pkg::OFS_IRQ_FLAGS: st_d.rdata = {13'h0000, st_q.flags};
				timer_pkg::OFS_IRQ_CTRL: st_d.rdata = st_q.irq_ctrl;
				default: st_d.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
			st_q.ctrl1 <= timer_pkg::CTRL_RESET;
			st_q.ctrl2 <= timer_pkg::CTRL_RESET;
			st_q.ctrl3 <= timer_pkg::CTRL_RESET;
			st_q.cnt1 <= timer_pkg::COUNT_RESET;
			st_q.cnt2 <= timer_pkg::COUNT_RESET;
			st_q.cnt3 <= timer_pkg::COUNT_RESET;
			st_q.per1 <= timer_pkg::PERIOD_RESET;
			st_q.per2 <= timer_pkg::PERIOD_RESET;
			st_q.per3 <= timer_pkg::PERIOD_RESET;
			st_q.irq_ctrl <= timer_pkg::IRQ_CTRL_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus_rdata = st_q.rdata;
	assign irq_out.req = st_q.irq;
	assign irq_out.prio_first = st_q.irq_ctrl[6:4];
	assign irq_out.prio_lower = st_q.irq_ctrl[10:8];
	assign irq_out.prio_upper = st_q.irq_ctrl[14:12];

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	logic wr_cnt1;
	assign wr_cnt1 = bus_req.wr && bus_req.addr == timer_pkg::OFS_FIRST_COUNT;
	sequence s_sync_tick;
		ptick1 && st_q.ctrl1[timer_pkg::SRC_BIT]
			&& st_q.ctrl1[timer_pkg::SYNC_BIT] && !bus_req.wr
			##1 !bus_req.wr ##1 !idle_mode;
	endsequence

	a_stop_holds: assert property (
		!st_q.ctrl1[timer_pkg::RUN_BIT] && !wr_cnt1 |=> $stable(st_q.cnt1))
		else $error("first timer moved while stopped");

	a_idle_halts: assert property (
		idle_mode && st_q.ctrl1[timer_pkg::IDLE_BIT] && !wr_cnt1
		|=> $stable(st_q.cnt1))
		else $error("first timer moved in idle with stop set");

	a_prescale_limit: assert property (
		ptick1 |-> st_q.pre1 >= presc_lim(
		st_q.ctrl1[timer_pkg::PRE_HI:timer_pkg::PRE_LO]))
		else $error("prescaler ticked early");

	a_sync_delay: assert property (
		s_sync_tick |-> tick1)
		else $error("synchronised tick not two cycles late");

	a_unsync_direct: assert property (
		ptick1 && st_q.ctrl1[timer_pkg::SRC_BIT]
		&& !st_q.ctrl1[timer_pkg::SYNC_BIT] |-> tick1)
		else $error("unsynchronised tick delayed");

	a_wrap_flag: assert property (
		tick1 && !gated1 && st_q.cnt1 == st_q.per1 && !wr_cnt1
		|=> st_q.cnt1 == 16'h0000 && st_q.flags[0])
		else $error("period match did not wrap and flag");

	a_gate_flag: assert property (
		run1 && gated1 && gfall[0] |=> st_q.flags[0])
		else $error("gate falling edge did not flag");

	a_pair_carry: assert property (
		paired && tick2 && st_q.cnt2 == 16'hFFFF && !bus_req.wr
		&& {st_q.cnt3, st_q.cnt2} != {st_q.per3, st_q.per2}
		|=> st_q.cnt2 == 16'h0000 && st_q.cnt3 == $past(st_q.cnt3) + 16'h0001)
		else $error("pair carry into upper word wrong");

	a_pair_irq: assert property (
		paired && !st_q.flags[1] |=> !st_q.flags[1])
		else $error("lower flag set while paired");

	a_ctrl_reserved: assert property (
		bus_req.rd && bus_req.addr == timer_pkg::OFS_LOWER_CTRL
		|=> (bus_rdata & ~timer_pkg::LOWER_CTRL_MASK) == 16'h0000)
		else $error("reserved control bits read nonzero");

endmodule

// ### test/paired_timers_bench.sv
// self-checking bench for the three-timer block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) \
	cmp_count++; \
	if ((gt) !== (ex)) begin \
		err_total++; \
		$display("wrong value %s exp %h got %h", nm, ex, gt); \
	end
module paired_timers_bench;
	logic sys_clk;
	logic rst_b;
	timer_pkg::bus_req_type req;
	logic [15:0] bus_rdata;
	logic idle_mode;
	timer_pkg::count_pins_type count_pins;
	timer_pkg::irq_out_type irq_out;
	int err_total;
	int cmp_count;
	int seed;
	int idx;
	logic [15:0] last;
	logic [15:0] v1;
	logic [15:0] v2;
	logic [15:0] per;
	logic [2:0] tog;
	logic [2:0] lvl;
	logic [7:0] ph;
	logic [3:0] cofs [3] = '{4'h0, 4'h3, 4'h6};
	logic [15:0] masks [3] = '{16'hA076, 16'hA07A, 16'hA072};
	int divs [4] = '{1, 8, 64, 256};

	paired_timers i_dut (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.bus_req(req),
		.bus_rdata(bus_rdata),
		.idle_mode(idle_mode),
		.count_pins(count_pins),
		.irq_out(irq_out)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// pin stimulus: square wave of four cycles or a static level
	always @(posedge sys_clk) begin
		ph <= ph + 8'h01;
		count_pins <= (tog & {3{ph[1]}}) | (~tog & lvl);
	end

	task automatic drive(input logic w, input logic r, input logic [3:0] a,
		input logic [15:0] d);
		req <= '{w, r, a, d};
		@(negedge sys_clk);
		last = bus_rdata;
		@(posedge sys_clk);
	endtask

	task automatic idle(input int n);
		repeat (n) drive(1'b0, 1'b0, 4'h0, 16'h0000);
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		drive(1'b1, 1'b0, a, d);
		idle(1);
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] q);
		drive(1'b0, 1'b1, a, 16'h0000);
		idle(1);
		q = last;
	endtask

	// count advance between two reads exactly d cycles apart
	task automatic rate(input logic [3:0] a, input int d,
		output logic [15:0] df);
		drive(1'b0, 1'b1, a, 16'h0000);
		idle(1);
		v1 = last;
		idle(d - 2);
		rd(a, df);
		df = df - v1;
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		#900000;
		err_total++;
		stop_test();
	end

	initial begin
		seed = 32'h683e;
		err_total = 0;
		cmp_count = 0;
		req = '0;
		idle_mode = 1'b0;
		count_pins = '0;
		tog = 3'b000;
		lvl = 3'b000;
		ph = 8'h00;
		rst_b = 1'b0;
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(cofs[i], v2);
			`CHK("ctrl reset", 16'h0000, v2)
			rd(cofs[i] + 4'h2, v2);
			`CHK("period reset", 16'hFFFF, v2)
			wr(cofs[i], 16'hFFFF);
			rd(cofs[i], v2);
			`CHK("ctrl bits", masks[i], v2)
			wr(cofs[i], 16'h0000);
		end
		rd(4'hF, v2);
		`CHK("unmapped", 16'h0000, v2)
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			for (int c = 0; c < 4; c++) begin
				wr(cofs[i], 16'h8000 | (16'(c) << 4));
				rate(cofs[i] + 4'h1, 512, v2);
				`CHK("prescaled ticks", 16'(512 / divs[c]), v2)
			end
			wr(cofs[i], 16'h0030);
			rate(cofs[i] + 4'h1, 64, v2);
			`CHK("stopped ticks", 16'h0000, v2)
		end
		$display("test prescale done");
		idle_mode <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			wr(cofs[i], 16'hA000);
			rate(cofs[i] + 4'h1, 64, v2);
			`CHK("idle halted", 16'h0000, v2)
			wr(cofs[i], 16'h8000);
			rate(cofs[i] + 4'h1, 64, v2);
			`CHK("idle running", 16'h0040, v2)
			wr(cofs[i], 16'h0000);
		end
		idle_mode <= 1'b0;
		$display("test idle done");
		for (int i = 0; i < 3; i++) begin
			wr(4'h9, 16'h0007);
			wr(cofs[i], 16'h8040);
			rate(cofs[i] + 4'h1, 64, v2);
			`CHK("gate low", 16'h0000, v2)
			lvl[i] <= 1'b1;
			idle(4);
			rate(cofs[i] + 4'h1, 64, v2);
			`CHK("gate high", 16'h0040, v2)
			lvl[i] <= 1'b0;
			idle(4);
			rd(4'h9, v2);
			`CHK("gate flag", 1'b1, v2[i])
			wr(cofs[i], 16'h8042);
			lvl[i] <= 1'b1;
			idle(8);
			rate(cofs[i] + 4'h1, 64, v2);
			`CHK("gate ignored", 16'h0000, v2)
			lvl[i] <= 1'b0;
			wr(cofs[i], 16'h0000);
		end
		$display("test gate done");
		for (int j = 0; j < 4; j++) begin
			idx = (j < 2) ? 0 : j - 1;
			wr(cofs[idx], 16'h8012 | ((j == 1) ? 16'h0004 : 16'h0000));
			tog[idx] <= 1'b1;
			idle(16);
			rate(cofs[idx] + 4'h1, 256, v2);
			`CHK("pin edges", 16'h0008, v2)
			tog[idx] <= 1'b0;
			wr(cofs[idx], 16'h0000);
		end
		$display("test external done");
		per = 16'h0002 + 16'($random(seed) & 15);
		wr(4'h9, 16'h0007);
		wr(4'h2, per);
		wr(4'h1, 16'h0000);
		wr(4'h0, 16'h8000);
		repeat (6) begin
			idle($random(seed) & 7);
			rd(4'h1, v2);
			`CHK("count in period", 1'b1, v2 <= per)
		end
		idle(24);
		rd(4'h9, v2);
		`CHK("match flag", 1'b1, v2[0])
		wr(4'hA, 16'h0001);
		idle(2);
		`CHK("first request", 1'b1, irq_out.req[0])
		wr(4'h0, 16'h0000);
		$display("test period done");
		wr(4'hA, 16'h3006);
		wr(4'h5, 16'h0010);
		wr(4'h8, 16'h0001);
		wr(4'h4, 16'h0000);
		wr(4'h7, 16'h0001);
		wr(4'h6, 16'h0030);
		wr(4'h9, 16'h0007);
		wr(4'h3, 16'h8008);
		idle(40);
		wr(4'h3, 16'h0008);
		rd(4'h7, v2);
		`CHK("pair wrap upper", 16'h0000, v2)
		rd(4'h9, v2);
		`CHK("pair flags", 3'h4, v2[2:0])
		`CHK("pair request", 3'h4, irq_out.req)
		`CHK("pair priority", 3'h3, irq_out.prio_upper)
		wr(4'h5, 16'hFFFF);
		wr(4'h8, 16'hFFFF);
		wr(4'h4, 16'hFFF0);
		wr(4'h7, 16'h0000);
		wr(4'h3, 16'h8008);
		idle(40);
		wr(4'h3, 16'h0008);
		rd(4'h7, v2);
		`CHK("pair carry", 16'h0001, v2)
		rate(4'h4, 32, v2);
		`CHK("pair stopped", 16'h0000, v2)
		wr(4'h3, 16'h8000);
		rate(4'h7, 32, v2);
		`CHK("split upper", 16'h0000, v2)
		rate(4'h4, 32, v2);
		`CHK("split lower", 16'h0020, v2)
		idle_mode <= 1'b1;
		wr(4'h3, 16'h8008);
		rate(4'h4, 32, v2);
		`CHK("pair idle run", 16'h0020, v2)
		wr(4'h6, 16'h2000);
		rate(4'h4, 32, v2);
		`CHK("pair idle stop", 16'h0000, v2)
		idle_mode <= 1'b0;
		$display("test pair done");
		stop_test();
	end
endmodule
